/* design/core_rf_defines.svh */
// Constants for the working register file and status flag block
// Summary of operation
// - Next instruction fetched while current one executes
// - Thirty-two 8-bit registers, single-cycle access
// - Two operands out, result written back
// - Two read/write port widths (8 and 16 bits) supported
// - Registers 26..31 form X, Y, Z pointers
// - Register n visible at data address n
// - Pointer into register range hits register
// - Status bit 7 gates every interrupt
// - Interrupt taken clears gate, return sets it
// - Dedicated instructions set or clear gate
// - Status bit 6 is bit copy store
// - Status bit 5 records low nibble carry
// - Status bit 4 equals negative xor overflow
// - Status bit 3 records two's complement overflow
// - Status bit 2 is result sign bit
// - Status bit 1 set on zero result
// - Status bit 0 records carry
`ifndef CORE_RF_DEFINES_SVH
`define CORE_RF_DEFINES_SVH

// ==========================================================================
// Sizes
`define RF_NUM_REGS    32
`define RF_WB_ADR_W    8

// ==========================================================================
// Register indexes; byte address on the bus is four times the index
`define RF_IDX_GPR_FIRST  6'h00
`define RF_IDX_GPR_LAST   6'h1f
`define RF_IDX_STATUS     6'h20

// ==========================================================================
// Pointer pair base registers (low byte; high byte is base plus one)
`define RF_PTR_X_LO  5'h1a
`define RF_PTR_Y_LO  5'h1c
`define RF_PTR_Z_LO  5'h1e

// Top of the data addresses that land in the register file
`define RF_DS_TOP    16'h001f

// ==========================================================================
// Status flag bit positions
`define FLAG_I  7
`define FLAG_T  6
`define FLAG_H  5
`define FLAG_S  4
`define FLAG_V  3
`define FLAG_N  2
`define FLAG_Z  1
`define FLAG_C  0

// ==========================================================================
// Reset values
`define RESET_FLAGS    8'h00
`define RESET_INSTR    16'h0000
`define RESET_PC       16'h0000
`define RESET_WB_DATA  32'h0000_0000

`endif

/* design/core_rf_pkg.sv */
// Types shared by the working register file and its neighbours
package core_rf_pkg;

   typedef enum logic [2:0] {
      FOP_NONE        = 3'h0,
      FOP_BIT_STORE   = 3'h1,
      FOP_BIT_LOAD    = 3'h3,
      FOP_GATE_SET    = 3'h2,
      FOP_GATE_CLR    = 3'h6,
      FOP_IRQ_RETURN  = 3'h7
   } flag_op_t;

   typedef enum logic [1:0] {
      WR_NONE = 2'h0,
      WR_B8   = 2'h1,
      WR_W16  = 2'h2
   } wr_mode_t;

   // Decoder/ALU request for one execute cycle
   typedef struct packed {
      logic [4:0]  rd_a_sel;
      logic [4:0]  rd_b_sel;
      logic [3:0]  rd_w_pair;
      wr_mode_t    wr_mode;
      logic [4:0]  wr_sel;
      logic [15:0] wr_data;
      logic        h_we;
      logic        v_we;
      logic        n_we;
      logic        z_we;
      logic        c_we;
      logic        h_val;
      logic        v_val;
      logic        c_val;
      flag_op_t    op;
      logic [4:0]  bit_reg;
      logic [2:0]  bit_sel;
      logic        irq_take;
   } core_req_t;

   // Data space access (direct address or through a pointer pair)
   typedef struct packed {
      logic        en;
      logic        we;
      logic        use_ptr;
      logic [1:0]  ptr_idx;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ds_req_t;

   // Answers to the core
   typedef struct packed {
      logic [7:0]  rd_a;
      logic [7:0]  rd_b;
      logic [15:0] rd_w;
      logic [7:0]  ds_rdata;
      logic        ds_hit;
   } core_rsp_t;

   // Complete block state
   typedef struct packed {
      logic [31:0][7:0] gpr;
      logic [7:0]       flags;
      logic [15:0]      pc;
      logic [15:0]      instr;
      core_rsp_t        rsp;
      logic [31:0]      wb_dat;
      logic             wb_ack;
      logic             irq_gated;
   } rf_state_t;

endpackage

/* design/core_rf.sv */
// Working register file, status flags, fetch stage and Wishbone register view
`include "core_rf_defines.svh"

module core_rf (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   // Program memory fetch
   output logic [15:0]                   prog_addr_o,
   input  wire logic [15:0]              prog_data_i,
   input  wire logic                     pc_load_i,
   input  wire logic [15:0]              pc_target_i,
   output logic [15:0]                   instr_o,
   // Execute side
   input  wire core_rf_pkg::core_req_t   core_req_i,
   output core_rf_pkg::core_rsp_t        core_rsp_o,
   input  wire core_rf_pkg::ds_req_t     ds_req_i,
   output logic [7:0]                    core_status_flags_o,
   output logic [15:0]                   ptr_x_o,
   output logic [15:0]                   ptr_y_o,
   output logic [15:0]                   ptr_z_o,
   // Interrupt gating
   input  wire logic                     irq_req_i,
   output logic                          irq_gated_o,
   // Classic Wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [`RF_WB_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o
);

   // =======================================================================
   // State
   core_rf_pkg::rf_state_t s_q;
   core_rf_pkg::rf_state_t s_d;

   localparam core_rf_pkg::rf_state_t RESET_STATE = '{
      gpr:       '0,
      flags:     `RESET_FLAGS,
      pc:        `RESET_PC,
      instr:     `RESET_INSTR,
      rsp:       '0,
      wb_dat:    `RESET_WB_DATA,
      wb_ack:    1'b0,
      irq_gated: 1'b0
   };

   // =======================================================================
   // Next state
   always_comb begin
      logic [4:0]  pair_lo;
      logic [4:0]  pair_hi;
      logic [4:0]  ptr_lo;
      logic [15:0] ds_addr;
      logic        ds_hit;
      logic [4:0]  ds_idx;
      logic [5:0]  wb_idx;
      logic        wb_req;
      logic        new_n;
      logic        new_z;
      logic        res_wide;
      logic [7:0]  fl;

      s_d      = s_q;
      pair_lo  = {core_req_i.wr_sel[4:1], 1'b0};
      pair_hi  = {core_req_i.wr_sel[4:1], 1'b1};
      ptr_lo   = `RF_PTR_X_LO;
      ds_addr  = ds_req_i.addr;
      ds_hit   = 1'b0;
      ds_idx   = 5'h00;
      wb_idx   = wb_adr_i[`RF_WB_ADR_W-1:2];
      wb_req   = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
      res_wide = (core_req_i.wr_mode == core_rf_pkg::WR_W16);
      new_n    = 1'b0;
      new_z    = 1'b0;
      fl       = s_q.flags;

      // Fetch runs alongside execute; a jump drops the prefetched word
      if (pc_load_i) begin
         s_d.pc    = pc_target_i;
         s_d.instr = `RESET_INSTR;
      end else begin
         s_d.pc    = s_q.pc + 16'h0001;
         s_d.instr = prog_data_i;
      end

      // Operand reads come straight from the array in one cycle
      s_d.rsp.rd_a = s_q.gpr[core_req_i.rd_a_sel];
      s_d.rsp.rd_b = s_q.gpr[core_req_i.rd_b_sel];
      s_d.rsp.rd_w = {s_q.gpr[{core_req_i.rd_w_pair, 1'b1}],
                      s_q.gpr[{core_req_i.rd_w_pair, 1'b0}]};

      // Result write-back, byte or register pair
      case (core_req_i.wr_mode)
         core_rf_pkg::WR_B8: begin
            s_d.gpr[core_req_i.wr_sel] = core_req_i.wr_data[7:0];
         end
         core_rf_pkg::WR_W16: begin
            s_d.gpr[pair_lo] = core_req_i.wr_data[7:0];
            s_d.gpr[pair_hi] = core_req_i.wr_data[15:8];
         end
         default: begin
         end
      endcase

      // Data space: low 32 addresses are the registers, not memory
      case (ds_req_i.ptr_idx)
         2'h0:    ptr_lo = `RF_PTR_X_LO;
         2'h1:    ptr_lo = `RF_PTR_Y_LO;
         default: ptr_lo = `RF_PTR_Z_LO;
      endcase
      if (ds_req_i.use_ptr) begin
         ds_addr = {s_q.gpr[ptr_lo + 5'h01], s_q.gpr[ptr_lo]};
      end
      ds_hit = ds_req_i.en && (ds_addr <= `RF_DS_TOP);
      ds_idx = ds_addr[4:0];
      s_d.rsp.ds_hit   = ds_hit;
      s_d.rsp.ds_rdata = ds_hit ? s_q.gpr[ds_idx] : 8'h00;
      if (ds_hit && ds_req_i.we) begin
         s_d.gpr[ds_idx] = ds_req_i.wdata;
      end

      // Bus access: one word per register, low byte lane carries data
      s_d.wb_ack = wb_req;
      s_d.wb_dat = `RESET_WB_DATA;
      if (wb_req) begin
         if (wb_idx <= `RF_IDX_GPR_LAST) begin
            s_d.wb_dat = {24'h00_0000, s_q.gpr[wb_idx[4:0]]};
            if (wb_we_i && wb_sel_i[0]) begin
               s_d.gpr[wb_idx[4:0]] = wb_dat_i[7:0];
            end
         end else if (wb_idx == `RF_IDX_STATUS) begin
            s_d.wb_dat = {24'h00_0000, s_q.flags};
            if (wb_we_i && wb_sel_i[0]) begin
               fl = wb_dat_i[7:0];
            end
         end
      end

      // Arithmetic and logic flags
      new_n = res_wide ? core_req_i.wr_data[15] : core_req_i.wr_data[7];
      new_z = res_wide ? (core_req_i.wr_data == 16'h0000)
                       : (core_req_i.wr_data[7:0] == 8'h00);
      if (core_req_i.h_we) begin
         fl[`FLAG_H] = core_req_i.h_val;
      end
      if (core_req_i.v_we) begin
         fl[`FLAG_V] = core_req_i.v_val;
      end
      if (core_req_i.n_we) begin
         fl[`FLAG_N] = new_n;
      end
      if (core_req_i.z_we) begin
         fl[`FLAG_Z] = new_z;
      end
      if (core_req_i.c_we) begin
         fl[`FLAG_C] = core_req_i.c_val;
      end

      // Taking an interrupt clears the gate before any op, so a
      // return or set in the same cycle wins
      if (core_req_i.irq_take) begin
         fl[`FLAG_I] = 1'b0;
      end

      case (core_req_i.op)
         core_rf_pkg::FOP_BIT_STORE: begin
            fl[`FLAG_T] = s_q.gpr[core_req_i.bit_reg][core_req_i.bit_sel];
         end
         core_rf_pkg::FOP_BIT_LOAD: begin
            s_d.gpr[core_req_i.bit_reg][core_req_i.bit_sel] = s_q.flags[`FLAG_T];
         end
         core_rf_pkg::FOP_GATE_SET: begin
            fl[`FLAG_I] = 1'b1;
         end
         core_rf_pkg::FOP_GATE_CLR: begin
            fl[`FLAG_I] = 1'b0;
         end
         core_rf_pkg::FOP_IRQ_RETURN: begin
            fl[`FLAG_I] = 1'b1;
         end
         default: begin
         end
      endcase

      // Sign is never stored independently, even after a bus write
      fl[`FLAG_S] = fl[`FLAG_N] ^ fl[`FLAG_V];
      s_d.flags   = fl;

      // Gate uses the current flag: a clear this cycle blocks at once
      s_d.irq_gated = irq_req_i && s_q.flags[`FLAG_I]
                      && !core_req_i.irq_take
                      && (core_req_i.op != core_rf_pkg::FOP_GATE_CLR);
   end

   // =======================================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= RESET_STATE;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // =======================================================================
   // Outputs
   assign prog_addr_o         = s_q.pc;
   assign instr_o             = s_q.instr;
   assign core_rsp_o          = s_q.rsp;
   assign core_status_flags_o = s_q.flags;
   assign ptr_x_o             = {s_q.gpr[`RF_PTR_X_LO + 5'h01], s_q.gpr[`RF_PTR_X_LO]};
   assign ptr_y_o             = {s_q.gpr[`RF_PTR_Y_LO + 5'h01], s_q.gpr[`RF_PTR_Y_LO]};
   assign ptr_z_o             = {s_q.gpr[`RF_PTR_Z_LO + 5'h01], s_q.gpr[`RF_PTR_Z_LO]};
   assign irq_gated_o         = s_q.irq_gated;
   assign wb_dat_o            = s_q.wb_dat;
   assign wb_ack_o            = s_q.wb_ack;

endmodule // core_rf

/* tb/core_rf_chk.sv */
// Port assertions for the register file block
module core_rf_chk (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic                   ce_i,
   input wire logic [15:0]            prog_data_i,
   input wire logic                   pc_load_i,
   input wire logic [15:0]            pc_target_i,
   input wire logic [15:0]            prog_addr_o,
   input wire logic [15:0]            instr_o,
   input wire core_rf_pkg::core_req_t core_req_i,
   input wire logic [7:0]             core_status_flags_o,
   input wire logic                   irq_req_i,
   input wire logic                   irq_gated_o,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       set_op;
   logic [7:0] f;
   assign f = core_status_flags_o;
   assign set_op = core_req_i.op inside {core_rf_pkg::FOP_GATE_SET,
                                         core_rf_pkg::FOP_IRQ_RETURN};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // =====
   // Status flags
   a_flag_reset: assert property (disable iff (1'b0) rst_i |=> f == 8'h00)
      else $error("flags not cleared by reset");
   a_sign_xor: assert property (f[4] == (f[2] ^ f[3]))
      else $error("sign flag is not n xor v");
   a_gate_take: assert property (ce_i && core_req_i.irq_take && !set_op |=> !f[7])
      else $error("interrupt entry left gate set");
   a_gate_set: assert property (ce_i && set_op |=> f[7])
      else $error("gate not set");
   a_gate_mask: assert property (ce_i |=> irq_gated_o == $past(irq_req_i && f[7]
      && !core_req_i.irq_take && core_req_i.op != core_rf_pkg::FOP_GATE_CLR))
      else $error("interrupt gating wrong");
   // =====
   // Fetch and bus
   a_fetch_pipe: assert property (ce_i && !pc_load_i |=> instr_o == $past(prog_data_i))
      else $error("prefetched word lost");
   a_fetch_flush: assert property (ce_i && pc_load_i |=> instr_o == 16'h0000)
      else $error("jump did not drop prefetched word");
   a_jump_target: assert property (ce_i && pc_load_i |=> prog_addr_o == $past(pc_target_i))
      else $error("jump target not loaded");
   a_pc_step: assert property (ce_i && !pc_load_i |=> prog_addr_o == $past(prog_addr_o) + 16'h0001)
      else $error("fetch address did not advance");
   a_ack_next: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus answer late");
   a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("bus answer held");
endmodule // core_rf_chk

bind core_rf core_rf_chk u_core_rf_chk (.*);

/* tb/prog_mem_model.sv */
// Program memory model feeding the fetch stage
module prog_mem_model (
   input  wire logic [15:0] addr_i,
   output logic      [15:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each address gives a distinct word, so a stale prefetch shows
   assign data_o = {addr_i[7:0] ^ 8'h5a, addr_i[15:8] + 8'h33};
endmodule // prog_mem_model

/* tb/core_rf_tb.sv */
// Self-checking bench for the register file block
module core_rf_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clk_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic                   pc_load = 1'b0;
   logic                   ce = 1'b1;
   logic [15:0]            pc_tgt = 16'h0000;
   logic [15:0]            tick = 16'h0000;
   logic [15:0]            p_adr, p_dat, px, py, pz;
   core_rf_pkg::core_req_t req = '0;
   core_rf_pkg::ds_req_t   ds = '0;
   core_rf_pkg::core_rsp_t rsp;
   logic [7:0]             fl;
   logic [7:0]             adr = 8'h00;
   logic [7:0]             sh [32] = '{default: 8'h00};
   logic                   irq = 1'b0, cyc = 1'b0, we = 1'b0, gated, ack;
   logic [31:0]            wd = 32'h0000_0000, rd, got;
   logic [31:0]            seed = 32'h0000_0131;
   int                     n_mismatch = 0, n_tests = 0;

   core_rf u_core_rf (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .prog_addr_o(p_adr),
      .prog_data_i(p_dat), .pc_load_i(pc_load), .pc_target_i(pc_tgt), .instr_o(),
      .core_req_i(req), .core_rsp_o(rsp), .ds_req_i(ds), .core_status_flags_o(fl),
      .ptr_x_o(px), .ptr_y_o(py), .ptr_z_o(pz), .irq_req_i(irq), .irq_gated_o(gated),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));
   prog_mem_model u_prog_mem_model (.addr_i(p_adr), .data_o(p_dat));

   always #5 clk_i = ~clk_i;
   // Jumps every eighth cycle keep the flush path busy under the fetch check
   always @(posedge clk_i) begin
      tick <= tick + 16'h0001;
      pc_load <= &tick[2:0];
      pc_tgt <= {tick[7:0], 8'h40};
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [3:0] nzsv(input logic [7:0] v, input logic ov);
      return {v[7] ^ ov, ov, v[7], v == 8'h00};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // =====
   // Drivers: entered and left on a rising edge
   task automatic exec(input core_rf_pkg::core_req_t r, input core_rf_pkg::ds_req_t d);
      req <= r;
      ds <= d;
      @(posedge clk_i);
      req <= '0;
      ds <= '0;
      @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end else begin
         got = rd;
         cyc <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   initial begin
      core_rf_pkg::core_req_t r;
      core_rf_pkg::ds_req_t   d;
      core_rf_pkg::flag_op_t  ops [5];
      logic [7:0]             v, n, m, e;
      int                     i;
      ops = '{core_rf_pkg::FOP_GATE_SET, core_rf_pkg::FOP_NONE, core_rf_pkg::FOP_IRQ_RETURN,
              core_rf_pkg::FOP_GATE_CLR, core_rf_pkg::FOP_IRQ_RETURN};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("status after reset", 32'(fl), 32'h0000_0000);
      wb(1'b0, 8'h84, 32'h0000_0000);
      chk("unmapped read", got, 32'h0000_0000);
      for (i = 0; i < 40; i++) begin
         n = rnd() & 8'h1f;
         m = rnd() & 8'h1f;
         v = rnd();
         r = '0;
         if (i[0]) begin
            wb(1'b1, {n[5:0], 2'b00}, {rnd(), rnd(), rnd(), v});
         end else begin
            r.wr_mode = core_rf_pkg::WR_B8;
            r.wr_sel = n[4:0];
            r.wr_data = {rnd(), v};
            {r.z_we, r.n_we, r.v_we, r.v_val} = {3'b111, m[0]};
            exec(r, '0);
            chk("flags s v n z", 32'(fl[4:1]), 32'(nzsv(v, m[0])));
         end
         sh[n[4:0]] = v;
         d = '0;
         d.en = 1'b1;
         d.addr = {8'h00, v & 8'h3f};
         r = '0;
         r.rd_a_sel = n[4:0];
         r.rd_b_sel = m[4:0];
         exec(r, d);
         chk("operands", 32'({rsp.rd_a, rsp.rd_b}), 32'({sh[n[4:0]], sh[m[4:0]]}));
         chk("data space", 32'({rsp.ds_hit, rsp.ds_rdata}),
             32'(d.addr[5] ? 9'h000 : {1'b1, sh[d.addr[4:0]]}));
      end
      // Pointer Z is aimed above the register range and must miss
      for (i = 0; i < 3; i++) begin
         v = rnd() & 8'h0f;
         r = '0;
         r.wr_mode = core_rf_pkg::WR_W16;
         r.wr_sel = 5'(26 + 2 * i);
         r.wr_data = {7'h00, i == 2, v};
         exec(r, '0);
         sh[26 + 2 * i] = v;
         sh[27 + 2 * i] = (i == 2) ? 8'h01 : 8'h00;
         d = '0;
         {d.en, d.we, d.use_ptr, d.ptr_idx, d.wdata} = {3'b111, 2'(i), rnd()};
         r = '0;
         r.rd_w_pair = 4'(13 + i);
         exec(r, d);
         chk("pair read", 32'(rsp.rd_w), 32'({sh[27 + 2 * i], v}));
         chk("pointer", 32'(i == 0 ? px : i == 1 ? py : pz), 32'({sh[27 + 2 * i], v}));
         chk("pointer hit", 32'(rsp.ds_hit), 32'(i != 2));
         if (i != 2)
            sh[v[4:0]] = d.wdata;
         wb(1'b0, {v[5:0], 2'b00}, 32'h0000_0000);
         chk("pointer write", got, 32'(sh[v[4:0]]));
      end
      irq <= 1'b1;
      for (i = 0; i < 5; i++) begin
         r = '0;
         r.op = ops[i];
         r.irq_take = (i == 1 || i == 4);
         exec(r, '0);
         chk("gate bit", 32'(fl[7]), 32'(!i[0]));
      end
      exec('0, '0);
      chk("gated request", 32'(gated), 32'h0000_0001);
      for (i = 0; i < 8; i++) begin
         n = rnd() & 8'h0f;
         v = rnd();
         r = '0;
         r.op = core_rf_pkg::FOP_BIT_STORE;
         {r.bit_reg, r.bit_sel} = {n[4:0], 3'(i)};
         {r.h_we, r.c_we, r.h_val, r.c_val} = {2'b11, v[1:0]};
         exec(r, '0);
         chk("t h c", 32'({fl[6:5], fl[0]}), 32'({sh[n[4:0]][i], v[1:0]}));
         r = '0;
         r.op = core_rf_pkg::FOP_BIT_LOAD;
         {r.bit_reg, r.bit_sel} = {5'(16 + i), 3'(7 - i)};
         exec(r, '0);
         sh[16 + i][7 - i] = sh[n[4:0]][i];
         wb(1'b0, 8'(4 * (16 + i)), 32'h0000_0000);
         chk("bit load", got, 32'(sh[16 + i]));
      end
      // Status byte over the bus, then a wide result with the clock enable on or off
      for (i = 0; i < 4; i++) begin
         v = rnd();
         wb(1'b1, 8'h80, {24'h00_0000, v});
         r = '0;
         r.wr_mode = core_rf_pkg::WR_W16;
         r.wr_sel = 5'h18;
         r.wr_data = {i[1] ? rnd() : 8'h00, 8'h00};
         {r.n_we, r.z_we} = 2'b11;
         ce <= i[0];
         exec(r, '0);
         ce <= 1'b1;
         e = {v[7:5], v[2] ^ v[3], v[3:0]};
         if (i[0]) begin
            e[4:1] = {r.wr_data[15] ^ v[3], v[3], r.wr_data[15], r.wr_data == 16'h0000};
            {sh[25], sh[24]} = r.wr_data;
         end
         chk("status flags", 32'(fl), 32'(e));
         wb(1'b0, 8'h80, 32'h0000_0000);
         chk("status via bus", got, 32'(e));
         wb(1'b0, 8'h64, 32'h0000_0000);
         chk("wide result", got, 32'(sh[25]));
      end
      print_verdict();
   end
endmodule // core_rf_tb
